// ==== hdl/tape_ctl_pkg.sv ====
// Constants and carrier types for the paper tape unit I/O controller
package tape_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int REPLY_NS      = 200;
  localparam int REPLY_CYC     = (REPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARMUP_MS     = 1000;
  localparam int WARMUP_CYC    = WARMUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WARM_W        = 28;
  localparam int REPLY_W       = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Strappable unit addresses
  localparam logic [7:0] ADDR_COMBO  = 8'h13;
  localparam logic [7:0] ADDR_SINGLE = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte bit positions
  localparam int CMD_DIS   = 0;
  localparam int CMD_EN    = 1;
  localparam int CMD_STOP  = 2;
  localparam int CMD_RUN   = 3;
  localparam int CMD_STEP  = 4;
  localparam int CMD_CONT  = 5;
  localparam int CMD_WRITE = 6;
  localparam int CMD_READ  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte bit positions
  localparam int ST_LOST  = 0;
  localparam int ST_STILL = 3;
  localparam int ST_BUSY  = 4;
  localparam int ST_MORE  = 5;
  localparam int ST_UNAV  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and buffer shape
  localparam logic RST_XMIT   = 1'b1;
  localparam int   BUF_DEPTH  = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       sel;
    logic       order;
    logic       rreq;
    logic       wdat;
    logic       sreq;
    logic       init;
    logic [7:0] lines;
  } host_pins_t;

  typedef struct packed {
    logic       rd_strobe;
    logic [7:0] rd_char;
    logic       rd_load;
    logic       rd_pwr_off;
    logic       pn_local;
    logic       pn_low;
    logic       pn_sync;
    logic       pn_pwr_ok;
  } tape_pins_t;

  typedef struct packed {
    logic       feed;
    logic       pn_power;
    logic       pn_motor;
    logic       pn_fire;
    logic [7:0] pn_data;
  } tape_out_t;

endpackage

// ==== hdl/tape_unit_io_controller.sv ====
// Paper tape reader and punch controller on a byte-wide multiplexor bus
//
// How it works
// - Selected flag sets when strobe meets the strapped address (13h or 03h).
// - Reply rises 200 ns after selection; only a selected unit serves requests.
// - Status: lost bit 0, stationary 3, busy 4, check-more 5, unavailable 7.
// - Command bits: disable, enable, stop, run, step, continuous, punch, reader.
// - Unavailable: reader load or power off; punch local or low tape.
// - Reader busy clears on a loaded character, sets on a host data request.
// - Punch busy from host character entering the buffer until punched.
// - Punch power-up holds busy about one second.
// - Stationary when motion and feed both reset; always zero in punch mode.
// - Check-more is lost OR stationary; always zero in punch mode.
// - Lost sets when a character lands before the previous was requested.
// - Command flags load only when the order strobe meets the selected flag.
// - Reader selection resets punch select, enabling reader status.
// - Punch selection sets punch select and power and raises pending interrupt.
// - Motion drives tape; continuous flag picks slew or single steps.
// - Bit 1 enables, bit 0 disables interrupts; pending still recorded.
// - Interrupt on reader character, entering punch mode, punch drained.
// - Pending flag reaches attention only while interrupts are enabled.
// - Stop halts reader after next character; in punch mode stops motor.
// - Run starts reader tape; in punch mode starts the motor.
// - Step mode advances one character then waits for a data request.
// - Init clears all flags, sets transmit; mode change does partial init.
`timescale 1ns/1ns
module tape_unit_io_controller #(
  parameter logic [7:0] DEV_ADDR = tape_ctl_pkg::ADDR_COMBO,
  parameter int         WARMUP   = tape_ctl_pkg::WARMUP_CYC
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_b_i,
  input  wire tape_ctl_pkg::host_pins_t host_i,
  input  wire tape_ctl_pkg::tape_pins_t tape_i,
  output logic                          handshake_reply_o,
  output logic [7:0]                    host_data_o,
  output logic                          attention_o,
  output tape_ctl_pkg::tape_out_t       tape_o
);
  import tape_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    host_pins_t              h1;
    host_pins_t              h2;
    host_pins_t              h3;
    tape_pins_t              t1;
    tape_pins_t              t2;
    tape_pins_t              t3;
    logic                    selected;
    logic [REPLY_W-1:0]      reply_cnt;
    logic                    reply;
    logic                    punch_sel;
    logic                    power;
    logic                    irq_pend;
    logic                    irq_en;
    logic                    motion;
    logic                    cont;
    logic                    feed;
    logic                    xmit;
    logic                    stop_pend;
    logic                    lost;
    logic                    motor;
    logic [7:0]              rd_buf;
    logic [7:0]              host_data;
    logic [BUF_DEPTH-1:0][7:0] fifo;
    logic                    wp;
    logic                    rp;
    logic [1:0]              cnt;
    logic                    warming;
    logic [WARM_W-1:0]       warm_cnt;
    logic                    fire;
    logic [7:0]              pn_data;
  } state_t;

  state_t q;
  state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Edges and derived status
  logic       sel_rise;
  logic       ord_rise;
  logic       rd_rise;
  logic       wr_rise;
  logic       st_rise;
  logic       strb_rise;
  logic       psync_rise;
  logic       pwr_rise;
  logic       addr_hit;
  logic       gated_order_strobe;
  logic       host_active;
  logic       unit_unavailable;
  logic       stationary_flag;
  logic       char_lost_flag;
  logic       busy_flag;
  logic       check_more_flag;
  logic       mode_change;
  logic [7:0] status_byte;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_out_ready;

  // Edges compare stage two against stage three of each synchroniser
  assign sel_rise   = q.h2.sel & ~q.h3.sel;
  assign ord_rise   = q.h2.order & ~q.h3.order;
  assign rd_rise    = q.h2.rreq & ~q.h3.rreq & q.selected;
  assign wr_rise    = q.h2.wdat & ~q.h3.wdat & q.selected;
  assign st_rise    = q.h2.sreq & ~q.h3.sreq & q.selected;
  assign strb_rise  = q.t2.rd_strobe & ~q.t3.rd_strobe & ~q.punch_sel;
  assign psync_rise = q.t2.pn_sync & ~q.t3.pn_sync;
  assign pwr_rise   = q.t2.pn_pwr_ok & ~q.t3.pn_pwr_ok;
  assign addr_hit   = q.h2.lines == DEV_ADDR;

  assign gated_order_strobe = ord_rise & q.selected;
  assign host_active = q.h2.sel ? addr_hit
                     : q.selected & (q.h2.order | q.h2.rreq | q.h2.wdat | q.h2.sreq);

  assign unit_unavailable = q.punch_sel ? (q.t2.pn_local | q.t2.pn_low)
                          : (q.t2.rd_load | q.t2.rd_pwr_off);
  assign stationary_flag = ~q.punch_sel & ~q.motion & ~q.feed;
  assign char_lost_flag  = ~q.punch_sel & q.lost;
  assign check_more_flag = char_lost_flag | stationary_flag;
  // Reader busy is the transmit flag: low only while an unrequested character waits
  assign busy_flag = q.punch_sel ? (q.cnt != 2'h0) | q.warming : q.xmit;

  always_comb begin
    status_byte           = 8'h00;
    status_byte[ST_LOST]  = char_lost_flag;
    status_byte[ST_STILL] = stationary_flag;
    status_byte[ST_BUSY]  = busy_flag;
    status_byte[ST_MORE]  = check_more_flag;
    status_byte[ST_UNAV]  = unit_unavailable;
  end

  // Mode change seen on a gated command
  assign mode_change = gated_order_strobe &
                       ((q.h2.lines[CMD_WRITE] & ~q.punch_sel) | (q.h2.lines[CMD_READ] & q.punch_sel));

  // Two-entry punch buffer; a write while full is dropped by the ready term
  assign buf_in_valid  = wr_rise & q.punch_sel;
  assign buf_in_ready  = q.cnt != BUF_FULL;
  assign buf_out_valid = q.cnt != 2'h0;
  assign buf_out_ready = psync_rise & q.motor & ~q.warming;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] c;
    logic       push;
    logic       pop;
    c    = q.h2.lines;
    push = buf_in_valid & buf_in_ready;
    pop  = buf_out_valid & buf_out_ready;
    d    = q;
    d.h1 = host_i;
    d.h2 = q.h1;
    d.h3 = q.h2;
    d.t1 = tape_i;
    d.t2 = q.t1;
    d.t3 = q.t2;
    d.fire = 1'b0;

    // Selection and reply
    if (sel_rise) begin
      d.selected = addr_hit;
    end
    if (!host_active) begin
      d.reply_cnt = '0;
      d.reply     = 1'b0;
    end else if (q.reply_cnt == REPLY_W'(REPLY_CYC - 1)) begin
      d.reply = 1'b1;
    end else begin
      d.reply_cnt = q.reply_cnt + REPLY_W'(1);
    end

    // Status read hands over the byte and clears sticky flags; later sets win
    if (st_rise) begin
      d.host_data = status_byte;
      d.irq_pend  = 1'b0;
      d.lost      = 1'b0;
    end

    // Reader data request
    if (rd_rise && !q.punch_sel) begin
      d.host_data = q.rd_buf;
      d.xmit      = 1'b1;
      if (q.motion && !q.cont) begin
        d.feed = 1'b1;
      end
    end

    // Character from the reader head
    if (strb_rise) begin
      d.rd_buf = q.t2.rd_char;
      if (!d.xmit) begin
        d.lost = 1'b1;
      end
      d.xmit     = 1'b0;
      d.irq_pend = 1'b1;
      if (!q.cont || q.stop_pend) begin
        d.feed = 1'b0;
      end
      if (q.stop_pend) begin
        d.motion    = 1'b0;
        d.stop_pend = 1'b0;
      end
    end

    // Punch buffer
    if (push) begin
      d.fifo[q.wp] = c;
      d.wp         = ~q.wp;
    end
    if (pop) begin
      d.pn_data = q.fifo[q.rp];
      d.fire    = 1'b1;
      d.rp      = ~q.rp;
      if (q.cnt == 2'h1 && !push) begin
        d.irq_pend = 1'b1;
      end
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

    // Punch warm-up hold-off
    if (pwr_rise) begin
      d.warming  = 1'b1;
      d.warm_cnt = '0;
    end else if (!q.t2.pn_pwr_ok) begin
      d.warming = 1'b0;
    end else if (q.warming) begin
      if (q.warm_cnt == WARM_W'(WARMUP - 1)) begin
        d.warming  = 1'b0;
        d.irq_pend = 1'b1;
      end else begin
        d.warm_cnt = q.warm_cnt + WARM_W'(1);
      end
    end

    // Command byte
    if (gated_order_strobe) begin
      if (mode_change) begin
        d.irq_pend  = 1'b0;
        d.cnt       = 2'h0;
        d.wp        = 1'b0;
        d.rp        = 1'b0;
        d.irq_en    = 1'b0;
        d.motion    = 1'b0;
        d.cont      = 1'b0;
        d.feed      = 1'b0;
        d.stop_pend = 1'b0;
        d.xmit      = RST_XMIT;
      end
      if (c[CMD_READ]) begin
        d.punch_sel = 1'b0;
      end
      if (c[CMD_WRITE]) begin
        d.punch_sel = 1'b1;
        d.power     = 1'b1;
        d.irq_pend  = 1'b1;
      end
      if (c[CMD_EN]) begin
        d.irq_en = 1'b1;
      end
      if (c[CMD_DIS]) begin
        d.irq_en = 1'b0;
      end
      if (c[CMD_STEP]) begin
        d.cont = 1'b0;
      end
      if (c[CMD_CONT]) begin
        d.cont = 1'b1;
      end
      if (c[CMD_STOP]) begin
        if (d.punch_sel) begin
          d.motor = 1'b0;
        end else if (d.motion) begin
          d.stop_pend = 1'b1;
        end
      end
      if (c[CMD_RUN]) begin
        if (d.punch_sel) begin
          d.motor = 1'b1;
        end else begin
          d.motion    = 1'b1;
          d.stop_pend = 1'b0;
          // Step mode only moves while no character is held
          d.feed      = d.cont | d.xmit;
        end
      end
    end

    // Full initialize keeps only the synchronisers, reply handshake, warm-up count and data holding registers
    if (q.h2.init) begin
      d.selected  = 1'b0;
      d.punch_sel = 1'b0;
      d.power     = 1'b0;
      d.irq_pend  = 1'b0;
      d.irq_en    = 1'b0;
      d.motion    = 1'b0;
      d.cont      = 1'b0;
      d.feed      = 1'b0;
      d.stop_pend = 1'b0;
      d.lost      = 1'b0;
      d.motor     = 1'b0;
      d.cnt       = 2'h0;
      d.wp        = 1'b0;
      d.rp        = 1'b0;
      d.warming   = 1'b0;
      d.fire      = 1'b0;
      d.xmit      = RST_XMIT;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q      <= '0;
      q.xmit <= RST_XMIT;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign handshake_reply_o = q.reply;
  assign host_data_o       = q.host_data;
  assign attention_o       = q.irq_pend & q.irq_en;
  assign tape_o.feed       = q.feed & ~q.punch_sel;
  assign tape_o.pn_power   = q.power;
  assign tape_o.pn_motor   = q.motor;
  assign tape_o.pn_fire    = q.fire;
  assign tape_o.pn_data    = q.pn_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  reply_delay_a: assert property ($rose(q.reply) |-> $past(host_active, REPLY_CYC))
    else $error("reply rose without a full delay of active strobe");

  select_flag_a: assert property (sel_rise && addr_hit && !q.h2.init |=> q.selected)
    else $error("matching address strobe did not select");

  status_byte_a: assert property (st_rise |=> host_data_o[2:1] == 2'h0 && !host_data_o[6]
                                  && host_data_o[ST_BUSY] == $past(busy_flag))
    else $error("status byte layout wrong");

  order_gate_a: assert property (ord_rise && !q.selected && !q.h2.init |=> $stable(q.irq_en)
                                 && $stable(q.punch_sel))
    else $error("command taken while unselected");

  write_cmd_a: assert property (gated_order_strobe && q.h2.lines[CMD_WRITE] && !q.h2.lines[CMD_READ]
                                && !q.h2.init |=> q.punch_sel && q.power && q.irq_pend)
    else $error("punch select command incomplete");

  lost_set_a: assert property (strb_rise && !q.xmit && !rd_rise && !q.h2.init && !mode_change
                               |=> q.lost)
    else $error("overrun not flagged");

  irq_enable_a: assert property (gated_order_strobe && q.h2.lines[CMD_EN] && !q.h2.lines[CMD_DIS]
                                 && !q.h2.init |=> q.irq_en)
    else $error("enable command ignored");

  punch_quiet_a: assert property (q.punch_sel |-> !status_byte[ST_STILL] && !status_byte[ST_MORE]
                                  && !status_byte[ST_LOST])
    else $error("reader flags visible in punch mode");

  warm_busy_a: assert property (pwr_rise && q.punch_sel && !q.h2.init && !mode_change
                                |=> busy_flag [*4])
    else $error("busy not held during punch warm-up");

  step_stop_a: assert property (strb_rise && !q.cont && !gated_order_strobe && !q.h2.init
                                |=> !q.feed)
    else $error("step mode kept feeding");

endmodule

// ==== verification/tape_mech_model.sv ====
// Behavioural reader and punch mechanisms on the tape side of the controller
`timescale 1ns/1ns
module tape_mech_model (
  input  wire logic                    clk_i,
  input  wire tape_ctl_pkg::tape_out_t ctl_i,
  input  wire logic [3:0]              unav_i,
  output tape_ctl_pkg::tape_pins_t     pins_o,
  output logic [7:0]                   char_o
);
  import tape_ctl_pkg::*;

  int         rd_cnt  = 0;
  int         age     = 99;
  int         pwr_cnt = 0;
  int         pn_cnt  = 0;
  logic [7:0] chr     = 8'h00;

  initial begin
    pins_o = '0;
    char_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One feed hole every 600 cycles of feed; data held 8 cycles, then it toggles
  // so that a late sample sees the held character only on alternate cycles, its inverse on the others
  always @(posedge clk_i) begin
    rd_cnt = ctl_i.feed ? rd_cnt + 1 : 0;
    if (rd_cnt == 600) begin
      rd_cnt = 0;
      age = 0;
      chr = 8'($urandom);
    end else if (age < 99) begin
      age++;
    end
    pwr_cnt = ctl_i.pn_power ? ((pwr_cnt < 99) ? pwr_cnt + 1 : 99) : 0;
    pn_cnt = (ctl_i.pn_motor && pwr_cnt > 10) ? pn_cnt + 1 : 0;
    if (pn_cnt == 250) pn_cnt = 0;
    #1;
    pins_o.rd_strobe  = (age < 4);
    pins_o.rd_char    = (age < 8) ? chr : ~pins_o.rd_char;
    pins_o.rd_load    = unav_i[0];
    pins_o.rd_pwr_off = unav_i[1];
    pins_o.pn_local   = unav_i[2];
    pins_o.pn_low     = unav_i[3];
    pins_o.pn_sync    = (pn_cnt > 0 && pn_cnt < 4);
    pins_o.pn_pwr_ok  = (pwr_cnt > 10);
    char_o = chr;
  end
endmodule

// ==== verification/tape_unit_io_controller_tb.sv ====
// Self-checking bench for the paper tape unit controller
`timescale 1ns/1ns
module tape_unit_io_controller_tb;
  import tape_ctl_pkg::*;

  localparam int WARM = 400;

  logic       sys_clk_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  host_pins_t host      = '0;
  tape_pins_t tpins;
  tape_out_t  tout;
  logic       reply;
  logic       attn;
  logic [7:0] hdata;
  logic [7:0] mchar;
  logic [3:0] unav      = 4'h0;
  logic       reply_q   = 1'b0;
  logic [7:0] d;
  int         fail_count = 0;
  int         checked    = 0;
  logic [7:0] exp_host[$];
  logic [7:0] exp_pn[$];

  tape_unit_io_controller #(.DEV_ADDR(ADDR_COMBO), .WARMUP(WARM)) tape_unit_io_controller_i (
    .sys_clk_i         (sys_clk_i),
    .rst_b_i           (rst_b_i),
    .host_i            (host),
    .tape_i            (tpins),
    .handshake_reply_o (reply),
    .host_data_o       (hdata),
    .attention_o       (attn),
    .tape_o            (tout)
  );

  tape_mech_model tape_mech_model_i (
    .clk_i  (sys_clk_i),
    .ctl_i  (tout),
    .unav_i (unav),
    .pins_o (tpins),
    .char_o (mchar)
  );

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_bit(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0:       return reply;
      1:       return attn;
      2:       return tpins.rd_strobe;
      default: return ~reply;
    endcase
  endfunction

  // Every wait is bounded; running out ends the run with a mismatch
  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("ERROR wait %0d expected 1 seen 0", k);
      wrap_up;
    end
  endtask

  // Kinds: 0 address, 1 command, 2 read data, 3 punch data, 4 status
  task automatic xfer(input int k, input logic [7:0] v);
    host.lines = v;
    host.sel   = (k == 0);
    host.order = (k == 1);
    host.rreq  = (k == 2);
    host.wdat  = (k == 3);
    host.sreq  = (k == 4);
    wait_on(0, 100);
    {host.sel, host.order, host.rreq, host.wdat, host.sreq} = 5'h00;
    wait_on(3, 100);
    tick(4);
  endtask

  task automatic status(input logic [7:0] e);
    exp_host.push_back(e);
    xfer(4, 8'h00);
  endtask

  task automatic rdata;
    exp_host.push_back(mchar);
    xfer(2, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Results are checked as they appear, against the oldest note
  // Falling edge: the outputs have settled after the edge that launched them
  always @(negedge sys_clk_i) begin
    reply_q <= reply;
    if (reply && !reply_q && exp_host.size() > 0) begin
      cmp_byte("host_data", exp_host.pop_front(), hdata);
    end
    if (tout.pn_fire === 1'b1 && exp_pn.size() > 0) begin
      cmp_byte("punch_data", exp_pn.pop_front(), tout.pn_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(712));
    tick(16);
    rst_b_i = 1'b1;
    tick(2);
    host.lines = ADDR_SINGLE;
    host.sel = 1'b1;
    tick(70);
    cmp_bit("reply", 1'b0, reply);
    host.sel = 1'b0;
    tick(5);
    xfer(0, ADDR_COMBO);
    status(8'h38);
    for (int i = 0; i < 2; i++) begin
      unav = 4'(1 << i);
      tick(4);
      status(8'hb8);
    end
    unav = 4'h0;
    // Slew with interrupts: the unrequested characters overrun
    xfer(1, 8'haa);
    cmp_bit("feed", 1'b1, tout.feed);
    wait_on(1, 1500);
    rdata();
    tick(1300);
    status(8'h21);
    xfer(1, 8'h01);
    wait_on(2, 1000);
    tick(10);
    cmp_bit("attention", 1'b0, attn);
    rdata();
    xfer(1, 8'h04);
    tick(700);
    cmp_bit("feed", 1'b0, tout.feed);
    status(8'h29);
    // Step mode moves only after a data request
    xfer(1, 8'h98);
    cmp_bit("feed", 1'b0, tout.feed);
    rdata();
    cmp_bit("feed", 1'b1, tout.feed);
    wait_on(2, 1000);
    tick(10);
    cmp_bit("feed", 1'b0, tout.feed);
    rdata();
    // Punch: mode change, warm-up, two buffered characters
    xfer(1, 8'h4a);
    cmp_bit("pn_power", 1'b1, tout.pn_power);
    cmp_bit("attention", 1'b1, attn);
    status(8'h10);
    wait_on(1, 1000);
    cmp_bit("pn_motor", 1'b1, tout.pn_motor);
    status(8'h00);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      exp_pn.push_back(d);
      xfer(3, d);
    end
    status(8'h10);
    wait_on(1, 2000);
    tick(1);
    cmp_bit("punch_left", 1'b1, exp_pn.size() == 0);
    for (int i = 2; i < 4; i++) begin
      unav = 4'(1 << i);
      tick(4);
      status(8'h80);
    end
    unav = 4'h0;
    xfer(1, 8'h04);
    cmp_bit("pn_motor", 1'b0, tout.pn_motor);
    // Back to the reader: partial initialize, tape must stay still
    xfer(1, 8'h80);
    cmp_bit("feed", 1'b0, tout.feed);
    status(8'h38);
    // Full initialize drops punch power and deselects
    host.init = 1'b1;
    tick(5);
    host.init = 1'b0;
    tick(4);
    cmp_bit("pn_power", 1'b0, tout.pn_power);
    xfer(0, ADDR_COMBO);
    status(8'h38);
    wrap_up;
  end
endmodule
